/* bench/mfd_diag_bench.sv */
// self-checking bench for the mic fault block
// assumes the scan model feeds samples and the tasks act as bus master
`timescale 1ns/10ps
`include "mfd_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module mfd_diag_bench;
  reg          clk_sys, nrst, awv, wv, bre, arv, rre, go, oc_det, ot_det;
  reg  [7:0]   awa, ara;
  reg  [31:0]  wd, d;
  reg  [119:0] lvl;
  reg  [3:0]   gap;
  reg  [1:0]   r;
  wire         awr, wrdy, bv, arr, rv, irq, pd_bias, pd_boost, pd_adc, sv, busy;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [3:0]   ssel;
  wire [11:0]  sdat;
  integer      fail_count, compares, i;

  mfd_diag dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre), .smp_valid(sv),
    .smp_sel(ssel), .smp_data(sdat), .oc_det(oc_det), .ot_det(ot_det), .irq(irq),
    .pd_bias(pd_bias), .pd_boost(pd_boost), .pd_adc(pd_adc));
  mfd_scan_model scan_u (.clk_sys(clk_sys), .nrst(nrst), .go(go), .lvl(lvl), .gap(gap),
    .smp_valid(sv), .smp_sel(ssel), .smp_data(sdat), .busy(busy));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task end_of_test;
    begin
      if (fail_count == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  task wr(input [7:0] a, input [31:0] v, output [1:0] resp);
    begin
      @(posedge clk_sys);
      awa <= a;
      wd  <= v;
      awv <= 1'b1;
      wv  <= 1'b1;
      bre <= 1'b1;
      do begin
        @(posedge clk_sys);
        if (awr) awv <= 1'b0;
        if (wrdy) wv <= 1'b0;
      end while (!bv);
      resp = bresp;
      bre <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, output [31:0] v, output [1:0] resp);
    begin
      @(posedge clk_sys);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
        @(posedge clk_sys);
        if (arr) arv <= 1'b0;
      end while (!rv);
      v = rdata;
      resp = rresp;
      rre <= 1'b0;
    end
  endtask

  task rc(input [7:0] a, input [31:0] e);
    begin
      rd(a, d, r);
      `CHK(d, e)
    end
  endtask

  task sweep(input [119:0] l, input [3:0] g);
    integer k;
    begin
      @(posedge clk_sys);
      lvl <= l;
      gap <= g;
      go  <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      k = 0;
      do begin
        @(posedge clk_sys);
        k++;
      end while (busy && k < 4000);
      if (busy)
        fail_count++;
      repeat (8) @(posedge clk_sys);
    end
  endtask

  initial begin
    #200000;
    fail_count++;
    end_of_test;
  end

  initial begin
    fail_count = 0;
    compares = 0;
    {nrst, awv, wv, bre, arv, rre, go, oc_det, ot_det} = 9'h000;
    {awa, ara, wd, lvl, gap} = 0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rc(`MFD_CFG, 32'h21); // mode and detector defaults
    rc(`MFD_FLT, 32'h0); // status cleared
    rc(`MFD_LIVE0, 32'h0); // live cleared
    rc(`MFD_ISTAT, 32'h0); // no event pending
    // open input on channel 0
    wr(`MFD_THR, 32'h1100, r);
    sweep(120'h200800300400300400300400000800, 4'h0);
    rc(`MFD_LIVE0, 32'h19); // open plus both shorts
    rc(`MFD_SUM, 32'h1); // channel summary
    rc(`MFD_ISTAT, 32'h1); // latch rise event
    `CHK(irq, 1'b0) // masked request
    wr(`MFD_IMASK, 32'h1, r);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b1) // unmasked request
    rc(`MFD_LAT0, 32'h19); // live fault keeps latch
    rc(`MFD_LAT0, 32'h19); // still latched
    wr(`MFD_ISTAT, 32'h1, r); // write one clears event
    rc(`MFD_ISTAT, 32'h0); // event cleared
    `CHK(irq, 1'b0) // request dropped
    // two-scan debounce, battery short on its own count
    wr(`MFD_THR, 32'h11110, r);
    sweep(120'hc00f00300400300c003c0400300400, 4'h3);
    rc(`MFD_LIVE0, 32'h0); // live follows last scan
    rc(`MFD_LIVE0 + 8'h04, 32'h2); // terminal short live
    rc(`MFD_LAT0 + 8'h04, 32'h0); // not yet persistent
    rc(`MFD_LAT0 + 8'h08, 32'h40); // battery short single scan
    sweep(120'hc00f00300400300c003c0400300400, 4'h0);
    rc(`MFD_LAT0 + 8'h04, 32'h2); // second scan latches
    rc(`MFD_LIVE0 + 8'h08, 32'h40); // both above battery level
    rc(`MFD_LAT0, 32'h19); // live low, read returns latch
    rc(`MFD_LAT0, 32'h0); // live low, read cleared it
    rc(`MFD_SUM, 32'h6); // summary follows latches
    // clear on every read
    wr(`MFD_CFG, 32'h20, r); // mode 0
    rc(`MFD_LAT0 + 8'h04, 32'h2); // read returns latch
    rc(`MFD_LAT0 + 8'h04, 32'h0); // read cleared despite live
    wr(`MFD_CFG, 32'h21, r); // back to mode 1
    // over-current, over-temperature and each power-down choice
    oc_det <= 1'b1;
    ot_det <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rc(`MFD_FLT, 32'h30); // flags at bits 4 and 5
    rc(`MFD_GLIVE, 32'h30); // detector enabled
    for (i = 0; i < 4; i++) begin
      wr(`MFD_CFG, 32'h21 | (i << 3), r);
      repeat (2) @(posedge clk_sys);
      `CHK(pd_adc, i[1]) // converters down on 10 and 11
      `CHK(pd_bias, i != 0) // bias down on any choice
      `CHK(pd_boost, i != 0) // boost down with bias
    end
    // unmapped and read-only places
    rd(8'h3c, d, r);
    `CHK({r, d}, {2'b10, 32'h0})
    wr(8'h40, 32'h1, r);
    `CHK(r, 2'b10)
    wr(`MFD_SUM, 32'hf, r);
    `CHK(r, 2'b00)
    rc(`MFD_SUM, 32'h4); // write ignored
    end_of_test;
  end
endmodule

/* bench/mfd_diag_sva.sv */
// concurrent checks on the ports of the mic fault block
// assumes one clock domain and a bind onto every mfd_diag instance
`timescale 1ns/10ps
module mfd_diag_chk (
  // clock and reset
  input wire        clk_sys,
  input wire        nrst,
  // register bus
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  // interrupt and power control
  input wire        irq,
  input wire        pd_bias,
  input wire        pd_boost,
  input wire        pd_adc
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_reset_quiet: assert property (
    !$past(nrst) |-> !irq && !pd_adc && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active right after reset");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_wr_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_rd_unmapped: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h3b
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rd_mapped: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h3b |=> s_axi_rresp == 2'b00)
    else $error("mapped read refused");
  a_pd_pair: assert property (pd_bias == pd_boost)
    else $error("bias and boost power-down differ");
  a_pd_full: assert property (pd_adc |-> pd_bias && pd_boost)
    else $error("converters down without bias down");

  c_irq: cover property ($rose(irq));
  c_pd_adc: cover property ($rose(pd_adc));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule

bind mfd_diag mfd_diag_chk chk_u (
  .clk_sys(clk_sys), .nrst(nrst), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq(irq), .pd_bias(pd_bias),
  .pd_boost(pd_boost), .pd_adc(pd_adc));

/* bench/mfd_scan_model.sv */
// scanning diagnostic converter: one sweep of ten slots on request
// assumes slot levels are held stable by the bench during a sweep
`timescale 1ns/10ps
module mfd_scan_model (
  // clock and reset
  input  wire         clk_sys,
  input  wire         nrst,
  // sweep request
  input  wire         go,
  input  wire [119:0] lvl,
  input  wire [3:0]   gap,
  // sample stream
  output reg          smp_valid,
  output reg  [3:0]   smp_sel,
  output reg  [11:0]  smp_data,
  output reg          busy
);
  reg [6:0] n_q;
  reg [3:0] w_q;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      smp_valid <= 1'b0;
      smp_sel   <= 4'h0;
      smp_data  <= 12'h000;
      busy      <= 1'b0;
      n_q       <= 7'h00;
      w_q       <= 4'h0;
    end else begin
      smp_valid <= 1'b0;
      // data is meaningless between samples
      smp_data <= ~smp_data;
      if (go && !busy) begin
        busy <= 1'b1;
        n_q  <= 7'h00;
        w_q  <= 4'h0;
      end else if (busy && w_q != 4'h0) begin
        w_q <= w_q - 4'h1;
      end else if (busy && n_q == 7'd80) begin
        busy <= 1'b0;
      end else if (busy) begin
        smp_valid <= 1'b1;
        smp_sel   <= n_q[6:3];
        smp_data  <= lvl[n_q[6:3]*12 +: 12];
        n_q       <= n_q + 7'h01;
        w_q       <= gap;
      end
    end
  end
endmodule

/* design/mfd_avg.v */
// eight-sample averager for the diagnostic converter results
// assumes samples of one slot arrive back to back, synchronous to clk_sys
`timescale 1ns/10ps
module mfd_avg #(
  parameter W  = 12,
  parameter SW = 4
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          nrst,
  // raw samples
  input  wire          in_valid,
  input  wire [SW-1:0] in_sel,
  input  wire [W-1:0]  in_data,
  // averaged result
  output reg           out_valid,
  output reg  [SW-1:0] out_sel,
  output reg  [W-1:0]  out_data
);

  reg  [W+2:0]  acc_q;
  reg  [2:0]    cnt_q;
  reg  [SW-1:0] sel_q;
  wire          fresh = (cnt_q == 3'h0) || (in_sel != sel_q);
  wire [W+2:0]  sum   = acc_q + {3'h0, in_data};

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acc_q     <= {(W+3){1'b0}};
      cnt_q     <= 3'h0;
      sel_q     <= {SW{1'b0}};
      out_valid <= 1'b0;
      out_sel   <= {SW{1'b0}};
      out_data  <= {W{1'b0}};
    end else begin
      out_valid <= 1'b0;
      if (in_valid) begin
        if (fresh) begin
          // slot change restarts the run
          acc_q <= {3'h0, in_data};
          cnt_q <= 3'h1;
          sel_q <= in_sel;
        end else if (cnt_q == 3'h7) begin
          out_valid <= 1'b1;
          out_sel   <= sel_q;
          out_data  <= sum[W+2:3];
          cnt_q     <= 3'h0;
        end else begin
          acc_q <= sum;
          cnt_q <= cnt_q + 3'h1;
        end
      end
    end
  end

endmodule

/* design/mfd_diag.v */
// microphone input fault classification, latching and reporting
// assumes a scanning converter delivering slot-tagged samples, AXI4-Lite host
`timescale 1ns/10ps
`include "mfd_regs.vh"

module mfd_diag #(
  parameter NCH = 4,
  parameter W   = 12
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          nrst,
  // register bus write
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  // register bus read
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // diagnostic converter samples
  input  wire          smp_valid,
  input  wire [3:0]    smp_sel,
  input  wire [W-1:0]  smp_data,
  // analog detectors
  input  wire          oc_det,
  input  wire          ot_det,
  // host interrupt and power control
  output reg           irq,
  output reg           pd_bias,
  output reg           pd_boost,
  output reg           pd_adc
);

  localparam NF = NCH * `MFD_NB;

  function ok_addr;
    input [7:0] a;
    begin
      ok_addr = (a[7:2] <= (`MFD_IMASK >> 2));
    end
  endfunction

  function [W-1:0] thr;
    input [3:0] f;
    begin
      thr = {f, {(W-4){1'b0}}} >> (W - 4 - `MFD_THR_SHIFT);
    end
  endfunction

  function [W-1:0] adiff;
    input [W-1:0] a;
    input [W-1:0] b;
    begin
      adiff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  function [31:0] bmask;
    input [3:0] s;
    begin
      bmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  // control registers
  reg  [`MFD_CFG_W-1:0] cfg_q;
  reg  [`MFD_THR_W-1:0] thr_q;
  reg  [2:0]            mask_q;
  reg  [2:0]            stat_q;

  // measurement and fault state
  reg  [W-1:0]          meas_q [0:9];
  reg                   eval_q;
  reg  [NF-1:0]         live_q;
  reg  [NF-1:0]         lat_q;
  reg  [NF-1:0]         pers_q;
  reg  [1:0]            glv_q;
  reg  [1:0]            glat_q;
  wire [NF-1:0]         raw;
  wire [NF-1:0]         pers;
  wire [NF-1:0]         lat_clr;

  // bus state
  reg                   aw_have_q;
  reg  [7:0]            awaddr_q;
  reg                   w_have_q;
  reg  [31:0]           wdata_q;
  reg  [3:0]            wstrb_q;

  wire                  avg_valid;
  wire [3:0]            avg_sel;
  wire [W-1:0]          avg_data;

  mfd_avg #(
    .W  (W),
    .SW (4)
  ) u_avg (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_valid  (smp_valid),
    .in_sel    (smp_sel),
    .in_data   (smp_data),
    .out_valid (avg_valid),
    .out_sel   (avg_sel),
    .out_data  (avg_data)
  );

  integer k;

  // battery slot closes a sweep
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      eval_q <= 1'b0;
      for (k = 0; k < 10; k = k + 1)
        meas_q[k] <= {W{1'b0}};
    end else begin
      eval_q <= avg_valid && (avg_sel == `MFD_S_BAT);
      if (avg_valid && (avg_sel <= `MFD_S_BAT))
        meas_q[avg_sel] <= avg_data;
    end
  end

  wire [W-1:0] vb = meas_q[`MFD_S_BIAS];
  wire [W-1:0] vv = meas_q[`MFD_S_BAT];
  wire         vv_hi = vv > `MFD_VBAT_HI;
  wire [W-1:0] t_term = thr(thr_q[`MFD_THR_TERM+3:`MFD_THR_TERM]);
  wire [W-1:0] t_bat  = thr(thr_q[`MFD_THR_BAT+3:`MFD_THR_BAT]);
  wire [W-1:0] t_gnd  = thr(thr_q[`MFD_THR_GND+3:`MFD_THR_GND]);
  wire [W-1:0] t_bias = thr(thr_q[`MFD_THR_BIAS+3:`MFD_THR_BIAS]);
  wire         mode   = cfg_q[`MFD_CFG_MODE];

  genvar c;
  genvar i;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      wire [W-1:0] vp = meas_q[2*c];
      wire [W-1:0] vm = meas_q[2*c+1];
      localparam B = c * `MFD_NB;
      assign raw[B+`MFD_B_GNDP] = vp < t_gnd;
      assign raw[B+`MFD_B_GNDM] = vm < t_gnd;
      assign raw[B+`MFD_B_BIASP] = (vb >= vp) && ((vb - vp) < t_bias);
      assign raw[B+`MFD_B_BIASM] = (vb >= vm) && ((vb - vm) < t_bias);
      assign raw[B+`MFD_B_OPEN] = raw[B+`MFD_B_BIASP] && raw[B+`MFD_B_GNDM];
      assign raw[B+`MFD_B_TERM] = adiff(vp, vm) < t_term;
      assign raw[B+`MFD_B_BATP] = (adiff(vv, vp) < t_bat)
                                || (vv_hi && (vp > `MFD_VBAT_HI));
      assign raw[B+`MFD_B_BATM] = (adiff(vv, vm) < t_bat)
                                || (vv_hi && (vm > `MFD_VBAT_HI));
      assign raw[B+`MFD_B_OVP] = vp > vb;
      assign raw[B+`MFD_B_OVM] = vm > vb;
      assign lat_clr[B+`MFD_NB-1:B] =
        (s_axi_arvalid && s_axi_arready && (s_axi_araddr[7:2] ==
         ((`MFD_LAT0 >> 2) + c))) ?
        (mode ? ~live_q[B+`MFD_NB-1:B] : {`MFD_NB{1'b1}}) :
        {`MFD_NB{1'b0}};
    end

    for (i = 0; i < NF; i = i + 1) begin : g_db
      localparam BAT = ((i % `MFD_NB) == `MFD_B_BATP) ||
                       ((i % `MFD_NB) == `MFD_B_BATM);
      reg  [3:0] pcnt_q;
      wire [3:0] need;
      if (BAT) begin : g_bat
        assign need = thr_q[`MFD_THR_BDB] ? `MFD_BDB_LONG : 4'h1;
      end else begin : g_gen
        assign need = {2'h0, thr_q[`MFD_THR_FDB+1:`MFD_THR_FDB]} + 4'h1;
      end
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
          pcnt_q <= 4'h0;
        else if (eval_q)
          pcnt_q <= raw[i] ? ((pcnt_q == `MFD_BDB_LONG) ? pcnt_q : pcnt_q + 4'h1)
                           : 4'h0;
      end
      assign pers[i] = pcnt_q >= need;
    end
  endgenerate

  // fault event edges
  wire [NF-1:0] lset  = pers & ~pers_q;
  wire [1:0]    glv_d = {ot_det & cfg_q[`MFD_CFG_OTEN], oc_det};
  wire [1:0]    gset  = glv_d & ~glv_q;
  wire          g_rd  = s_axi_arvalid && s_axi_arready &&
                        (s_axi_araddr[7:2] == (`MFD_FLT >> 2));
  wire [1:0]    gclr  = g_rd ? (mode ? ~glv_q : 2'h3) : 2'h0;
  wire [NF-1:0] lat_d = (lat_q & ~lat_clr) | lset;
  wire [1:0]    glat_d = (glat_q & ~gclr) | gset;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      live_q <= {NF{1'b0}};
      pers_q <= {NF{1'b0}};
      glv_q  <= 2'h0;
    end else begin
      if (eval_q)
        live_q <= raw;
      pers_q <= pers;
      glv_q  <= glv_d;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lat_q  <= {NF{1'b0}};
      glat_q <= 2'h0;
    end else begin
      lat_q  <= lat_d;
      glat_q <= glat_d;
    end
  end

  // write channel
  wire        aw_take = s_axi_awvalid && s_axi_awready;
  wire        w_take  = s_axi_wvalid && s_axi_wready;
  wire        do_wr   = aw_have_q && w_have_q && !s_axi_bvalid;
  wire        aw_have_d = aw_take || (aw_have_q && !do_wr);
  wire        w_have_d  = w_take || (w_have_q && !do_wr);
  wire        bvalid_d  = do_wr || (s_axi_bvalid && !s_axi_bready);
  wire [31:0] wm = bmask(wstrb_q);
  wire [5:0]  wa = awaddr_q[7:2];
  wire        wr_cfg = do_wr && (wa == (`MFD_CFG >> 2));
  wire        wr_thr = do_wr && (wa == (`MFD_THR >> 2));
  wire        wr_ist = do_wr && (wa == (`MFD_ISTAT >> 2));
  wire        wr_msk = do_wr && (wa == (`MFD_IMASK >> 2));
  wire [31:0] cfg_n = ({26'h0, cfg_q} & ~wm) | (wdata_q & wm);
  wire [31:0] thr_n = ({13'h0, thr_q} & ~wm) | (wdata_q & wm);
  wire [31:0] msk_n = ({29'h0, mask_q} & ~wm) | (wdata_q & wm);
  wire [2:0]  w1c   = wr_ist ? (wdata_q[2:0] & wm[2:0]) : 3'h0;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aw_have_q     <= 1'b0;
      awaddr_q      <= 8'h00;
      w_have_q      <= 1'b0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      cfg_q         <= `MFD_CFG_RST;
      thr_q         <= `MFD_THR_RST;
      mask_q        <= 3'h0;
    end else begin
      aw_have_q     <= aw_have_d;
      w_have_q      <= w_have_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_awready <= !aw_have_d && !bvalid_d;
      s_axi_wready  <= !w_have_d && !bvalid_d;
      if (aw_take)
        awaddr_q <= s_axi_awaddr;
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr)
        s_axi_bresp <= ok_addr(awaddr_q) ? 2'h0 : 2'h2;
      if (wr_cfg)
        cfg_q <= cfg_n[`MFD_CFG_W-1:0];
      if (wr_thr)
        thr_q <= thr_n[`MFD_THR_W-1:0];
      if (wr_msk)
        mask_q <= msk_n[2:0];
    end
  end

  // read channel
  reg  [31:0] rd_mux;
  integer     j;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr[7:2])
      (`MFD_CFG >> 2):   rd_mux = {26'h0, cfg_q};
      (`MFD_THR >> 2):   rd_mux = {13'h0, thr_q};
      (`MFD_FLT >> 2):   rd_mux = {26'h0, glat_q, 4'h0};
      (`MFD_GLIVE >> 2): rd_mux = {26'h0, glv_q, 4'h0};
      (`MFD_SUM >> 2): begin
        for (j = 0; j < NCH; j = j + 1)
          rd_mux[j] = |lat_q[j*`MFD_NB +: `MFD_NB];
      end
      (`MFD_ISTAT >> 2): rd_mux = {29'h0, stat_q};
      (`MFD_IMASK >> 2): rd_mux = {29'h0, mask_q};
      default: begin
        for (j = 0; j < NCH; j = j + 1) begin
          if (s_axi_araddr[7:2] == ((`MFD_LAT0 >> 2) + j))
            rd_mux[`MFD_NB-1:0] = lat_q[j*`MFD_NB +: `MFD_NB];
          if (s_axi_araddr[7:2] == ((`MFD_LIVE0 >> 2) + j))
            rd_mux[`MFD_NB-1:0] = live_q[j*`MFD_NB +: `MFD_NB];
        end
      end
    endcase
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= ok_addr(s_axi_araddr) ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  wire [2:0] sset = {gset[1] & ~glat_q[1], gset[0] & ~glat_q[0],
                     |(lset & ~lat_q)};
  wire [2:0] stat_d = (stat_q & ~w1c) | sset;

  wire       ot_flt = glat_q[1];
  wire [1:0] pdsel  = cfg_q[`MFD_CFG_PD_HI:`MFD_CFG_PD_LO];

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stat_q   <= 3'h0;
      irq      <= 1'b0;
      pd_bias  <= 1'b0;
      pd_boost <= 1'b0;
      pd_adc   <= 1'b0;
    end else begin
      stat_q   <= stat_d;
      irq      <= |(stat_d & mask_q);
      pd_bias  <= ot_flt && (pdsel != 2'h0);
      pd_boost <= ot_flt && (pdsel != 2'h0);
      pd_adc   <= ot_flt && pdsel[1];
    end
  end

endmodule

/* design/mfd_regs.vh */
// register map, field positions and reset values of the mic fault block
// assumes a 32-bit register bus with byte addresses in the low 8 bits
`ifndef MFD_REGS_VH
`define MFD_REGS_VH

// register byte offsets
`define MFD_CFG        8'h00
`define MFD_THR        8'h04
`define MFD_FLT        8'h08
`define MFD_SUM        8'h0c
`define MFD_LAT0       8'h10
`define MFD_LIVE0      8'h20
`define MFD_GLIVE      8'h30
`define MFD_ISTAT      8'h34
`define MFD_IMASK      8'h38

// configuration fields
`define MFD_CFG_MODE   0
`define MFD_CFG_PD_LO  3
`define MFD_CFG_PD_HI  4
`define MFD_CFG_OTEN   5
`define MFD_CFG_W      6
`define MFD_CFG_RST    6'h21

// threshold fields
`define MFD_THR_BAT    0
`define MFD_THR_TERM   4
`define MFD_THR_GND    8
`define MFD_THR_BIAS   12
`define MFD_THR_FDB    16
`define MFD_THR_BDB    18
`define MFD_THR_W      19
`define MFD_THR_RST    19'h00000

// per-channel fault bits
`define MFD_B_OPEN     0
`define MFD_B_TERM     1
`define MFD_B_GNDP     2
`define MFD_B_GNDM     3
`define MFD_B_BIASP    4
`define MFD_B_BIASM    5
`define MFD_B_BATP     6
`define MFD_B_BATM     7
`define MFD_B_OVP      8
`define MFD_B_OVM      9
`define MFD_NB         10

// device fault status bits
`define MFD_F_OC       4
`define MFD_F_OT       5

// interrupt status bits
`define MFD_I_CH       0
`define MFD_I_OC       1
`define MFD_I_OT       2

// measurement slots: 2c positive, 2c+1 negative, then bias, battery
`define MFD_S_BIAS     8
`define MFD_S_BAT      9

// 11.7 V battery level on a 16 V full-scale 12-bit code
`define MFD_VBAT_HI_MV 11700
`define MFD_FS_MV      16000
// code of 11700 mV * 4095 / 16000 mV, truncated
`define MFD_VBAT_HI    12'd2994
`define MFD_THR_SHIFT  8
`define MFD_AVG_N      8
`define MFD_BDB_LONG   4'h8

`endif
